// ==== adc_accumulator_window_detect_test.sv ====
// Self-checking bench for the accumulator, burst sequencer and window detector
`timescale 1ns/10ps
`default_nettype none
module adc_accumulator_window_detect_test;
  logic clk, rst_b, sfr_wr, burst_en, track_ext_en, conv_req, sar_tick, conv_done;
  logic conv_start_r, busy_r, window_match_r;
  logic [3:0] sfr_page;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_r;
  logic [2:0] shift_justify_field;
  logic [15:0] less_than_limit, conv_data;
  logic [6:0] burst_len;
  logic [15:0] fmt [6] = '{16'h03CD, 16'h01E6, 16'h00F3, 16'h0079, 16'hF340, 16'h03CD};
  logic [15:0] wv [5] = '{16'h003F, 16'h0040, 16'h0041, 16'h0080, 16'h0081};
  int fails = 0;
  int n_checks = 0;
  int n;
  adcawd_top uut (.clk(clk), .rst_b(rst_b), .sfr_page(sfr_page), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r), .shift_justify_field(shift_justify_field),
    .less_than_limit(less_than_limit), .burst_en(burst_en), .track_ext_en(track_ext_en), .burst_len(burst_len),
    .conv_req(conv_req), .sar_tick(sar_tick), .conv_done(conv_done), .conv_data(conv_data),
    .conv_start_r(conv_start_r), .busy_r(busy_r), .window_match_r(window_match_r));
  adcawd_conv_model model (.clk(clk), .rst_b(rst_b), .conv_start(conv_start_r), .sar_tick(sar_tick),
    .conv_done(conv_done), .conv_data(conv_data));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_page = pg;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  task automatic rdc(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    sfr_page = pg;
    sfr_addr = a;
    repeat (2) @(negedge clk);
    chk({8'h00, sfr_rdata_r}, {8'h00, exp});
  endtask
  // Software never touches the result bytes while a lockstep conversion runs
  task automatic wacc(input logic [15:0] v);
    wr(4'h0, 8'hBE, v[15:8]);
    wr(4'h0, 8'hBD, v[7:0]);
  endtask
  task automatic wait_start(input int lim);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (conv_start_r !== 1'b1 && n < lim);
    if (conv_start_r !== 1'b1) begin
      chk(16'h0000, 16'h0001);
      end_sim;
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic burst(input logic [5:0] tk, input logic ext, input int lo, input int hi);
    wr(4'hF, 8'hBD, {2'b00, tk});
    track_ext_en = ext;
    burst_en = 1'b1;
    burst_len = 7'h02;
    @(negedge clk);
    conv_req = 1'b1;
    // Request stays up until the first start shows; the sequencer ignores it once busy
    wait_start(60);
    conv_req = 1'b0;
    if (!ext) chk(n[15:0], 16'h0001);
    wait_start(80);
    chk({15'h0000, n >= lo && n <= hi}, 16'h0001);
    n = 0;
    while (busy_r !== 1'b0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk({15'h0000, busy_r}, 16'h0000);
    $display("burst test done");
  endtask
  task automatic window(input logic [15:0] gt, input logic [15:0] lt, input logic [4:0] exp);
    wr(4'h0, 8'hC4, gt[15:8]);
    wr(4'h0, 8'hC3, gt[7:0]);
    less_than_limit = lt;
    for (int i = 0; i < 5; i++) begin
      wacc(wv[i]);
      repeat (3) @(negedge clk);
      chk({15'h0000, window_match_r}, {15'h0000, exp[4-i]});
    end
    $display("window test done");
  endtask
  initial begin
    {sfr_wr, burst_en, track_ext_en, conv_req, rst_b} = 5'h00;
    sfr_page = 4'h0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    shift_justify_field = 3'h0;
    less_than_limit = 16'h0000;
    burst_len = 7'h00;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    rdc(4'hF, 8'hBD, 8'h1E);
    rdc(4'h0, 8'hC3, 8'hFF);
    rdc(4'h0, 8'hC4, 8'hFF);
    rdc(4'h0, 8'hBE, 8'h00);
    rdc(4'h0, 8'h10, 8'h00);
    wr(4'hF, 8'hBD, 8'hFF);
    rdc(4'hF, 8'hBD, 8'h3F);
    $display("register test done");
    wacc(16'h03CD);
    for (int c = 0; c < 6; c++) begin
      shift_justify_field = c[2:0];
      rdc(4'h0, 8'hBE, fmt[c][15:8]);
      rdc(4'h0, 8'hBD, fmt[c][7:0]);
    end
    shift_justify_field = 3'h0;
    $display("format test done");
    window(16'h0040, 16'h0080, 5'b00100);
    window(16'h0080, 16'h0040, 5'b10001);
    // Left-justified words with the limit low byte cleared, as software does for 8-bit use
    shift_justify_field = 3'h4;
    window(16'h1000, 16'h2000, 5'b00100);
    shift_justify_field = 3'h0;
    // Start to start is model latency 6, one cycle to enter tracking, then (64 - field) x 10 cycles
    burst(6'h3F, 1'b0, 17, 17);
    burst(6'h3E, 1'b0, 27, 27);
    // Extension adds three converter ticks, 17 to 24 cycles depending on tick phase
    burst(6'h3F, 1'b1, 34, 41);
    end_sim;
  end
endmodule
`default_nettype wire

// ==== adcawd_conv_model.sv ====
// Behavioural model of the converter core facing the sequencer
`timescale 1ns/10ps
`default_nettype none
module adcawd_conv_model #(
  parameter int LAT = 6,
  parameter int TICK = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic conv_start,
  output logic sar_tick,
  output logic conv_done,
  output logic [15:0] conv_data
);
  int cnt;
  int tk;
  logic [15:0] nxt;
  initial begin
    sar_tick = 1'b0;
    conv_done = 1'b0;
    conv_data = 16'h0000;
    cnt = 0;
    tk = 0;
    nxt = 16'h0123;
  end
  // Inputs change on the falling edge so the sequencer samples them settled
  always @(negedge clk) begin
    tk = (tk + 1) % TICK;
    sar_tick = (tk == 0);
    conv_done = 1'b0;
    // Word is only valid with the done pulse, so keep it moving otherwise
    conv_data = ~conv_data;
    if (cnt > 0) begin
      cnt--;
      if (cnt == 0) begin
        conv_done = 1'b1;
        conv_data = nxt;
        nxt = nxt + 16'h0111;
      end
    end
    if (!rst_b) begin
      cnt = 0;
    end else if (conv_start) begin
      cnt = LAT;
    end
  end
endmodule
`default_nettype wire

// ==== adcawd_pkg.sv ====
// Constants, register map and state type for the converter accumulator and window detector
// How it works
// - In burst mode each conversion after the first waits (64 - track field) x 50 ns of tracking.
// - The first conversion of a burst gets no burst track delay; the power-up delay covers it.
// - With track extension set, three extra converter clock cycles of tracking precede each conversion.
// - Bits 7 and 6 of the track-time register read as zero and software writes them as zero.
// - Writing a result byte loads the written value into that byte of the 16-bit accumulator.
// - With shifting on, the vacated top bits of the high result byte read as zero.
// - With shifting on, the top bits of the low result byte carry the bits shifted out of the high byte.
// - The output word is compared with the 16-bit limit pair at all times and the window flag raised on a match.
// - The window flag only drives the window_match_r output; no register read returns it as a status bit.
// - Inside or outside detection is chosen only by how the two limits relate to each other.
// - The greater-than limit is one 16-bit value from a high and a low byte register, both resetting to all ones.
// - With greater-than limit below less-than limit, the flag is set for words strictly between them.
// - Shift-and-justify codes 000 to 011 right-justify with 0 to 3 bit shift, 100 left-justifies, others reserved.
package adcawd_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] PAGE_MAIN = 4'h0;
  localparam logic [3:0] PAGE_CFG = 4'hF;
  localparam logic [7:0] ADDR_TRACK = 8'hBD;
  localparam logic [7:0] ADDR_RES_LO = 8'hBD;
  localparam logic [7:0] ADDR_RES_HI = 8'hBE;
  localparam logic [7:0] ADDR_GT_LO = 8'hC3;
  localparam logic [7:0] ADDR_GT_HI = 8'hC4;

  localparam logic [5:0] TRACK_RST = 6'h1E;
  localparam logic [7:0] RES_RST = 8'h00;
  localparam logic [7:0] GT_RST = 8'hFF;

  localparam logic [2:0] SJ_LEFT = 3'h4;

  // ****************************************
  // Timing
  // ****************************************
  localparam int TRACK_STEPS = 64;
  localparam int TRACK_UNIT_NS = 50;
  localparam int CLK_PERIOD_NS = 5;
  // Least time, so round up
  localparam int TRACK_UNIT_CYC = (TRACK_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] EXT_SAR_CYC = 2'h3;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_TRACK = 2'b01,
    S_EXT = 2'b10,
    S_CONV = 2'b11
  } adcawd_state_t;

endpackage

// ==== adcawd_top.sv ====
// Burst sequencer, result accumulator and window detector of the sampling converter
`timescale 1ns/10ps
`default_nettype none
module adcawd_top #(
  parameter int DATA_WIDTH = 10
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata_r,
  input wire logic [2:0] shift_justify_field,
  input wire logic [15:0] less_than_limit,
  input wire logic burst_en,
  input wire logic track_ext_en,
  input wire logic [6:0] burst_len,
  input wire logic conv_req,
  input wire logic sar_tick,
  input wire logic conv_done,
  input wire logic [15:0] conv_data,
  output logic conv_start_r,
  output logic busy_r,
  output logic window_match_r
);

  localparam int LJ_SHIFT = 16 - DATA_WIDTH;

  // ****************************************
  // Register file
  // ****************************************
  logic [5:0] tk_r, tk_nxt;
  logic [15:0] acc_r, acc_nxt;
  logic [7:0] gt_lo_r, gt_lo_nxt;
  logic [7:0] gt_hi_r, gt_hi_nxt;
  logic [7:0] rdata_nxt;
  logic match_nxt;
  logic [15:0] fmt;
  logic [15:0] gt_word;
  logic sel_main;
  logic sel_cfg;

  assign sel_main = (sfr_page == adcawd_pkg::PAGE_MAIN);
  assign sel_cfg = (sfr_page == adcawd_pkg::PAGE_CFG);
  assign gt_word = {gt_hi_r, gt_lo_r};

  // Read view of the accumulator
  always_comb begin
    case (shift_justify_field)
      3'h0, 3'h1, 3'h2, 3'h3: begin
        fmt = acc_r >> shift_justify_field[1:0];
      end
      adcawd_pkg::SJ_LEFT: begin
        fmt = acc_r << LJ_SHIFT;
      end
      default: begin
        // Reserved codes read as plain right-justified data
        fmt = acc_r;
      end
    endcase
  end

  always_comb begin
    tk_nxt = tk_r;
    acc_nxt = acc_r;
    gt_lo_nxt = gt_lo_r;
    gt_hi_nxt = gt_hi_r;
    rdata_nxt = 8'h00;
    if (conv_done) begin
      acc_nxt = conv_data;
    end
    // Software byte write lands after a coinciding conversion load
    if (sfr_wr && sel_cfg && sfr_addr == adcawd_pkg::ADDR_TRACK) begin
      tk_nxt = sfr_wdata[5:0];
    end
    if (sfr_wr && sel_main) begin
      case (sfr_addr)
        adcawd_pkg::ADDR_RES_LO: begin
          acc_nxt[7:0] = sfr_wdata;
        end
        adcawd_pkg::ADDR_RES_HI: begin
          acc_nxt[15:8] = sfr_wdata;
        end
        adcawd_pkg::ADDR_GT_LO: begin
          gt_lo_nxt = sfr_wdata;
        end
        adcawd_pkg::ADDR_GT_HI: begin
          gt_hi_nxt = sfr_wdata;
        end
        default: begin
          acc_nxt = acc_nxt;
        end
      endcase
    end
    if (sel_cfg && sfr_addr == adcawd_pkg::ADDR_TRACK) begin
      rdata_nxt = {2'b00, tk_r};
    end else if (sel_main) begin
      case (sfr_addr)
        adcawd_pkg::ADDR_RES_LO: rdata_nxt = fmt[7:0];
        adcawd_pkg::ADDR_RES_HI: rdata_nxt = fmt[15:8];
        adcawd_pkg::ADDR_GT_LO: rdata_nxt = gt_lo_r;
        adcawd_pkg::ADDR_GT_HI: rdata_nxt = gt_hi_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
    // Limits alone choose inside or outside detection
    if (gt_word < less_than_limit) begin
      match_nxt = (fmt > gt_word) && (fmt < less_than_limit);
    end else begin
      match_nxt = (fmt < less_than_limit) || (fmt > gt_word);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tk_r <= adcawd_pkg::TRACK_RST;
      acc_r <= {adcawd_pkg::RES_RST, adcawd_pkg::RES_RST};
      gt_lo_r <= adcawd_pkg::GT_RST;
      gt_hi_r <= adcawd_pkg::GT_RST;
      sfr_rdata_r <= 8'h00;
      window_match_r <= 1'b0;
    end else begin
      tk_r <= tk_nxt;
      acc_r <= acc_nxt;
      gt_lo_r <= gt_lo_nxt;
      gt_hi_r <= gt_hi_nxt;
      sfr_rdata_r <= rdata_nxt;
      window_match_r <= match_nxt;
    end
  end

  // ****************************************
  // Burst sequencer
  // ****************************************
  adcawd_pkg::adcawd_state_t state_r, state_nxt;
  logic [9:0] cnt_r, cnt_nxt;
  logic [1:0] ext_r, ext_nxt;
  logic [6:0] left_r, left_nxt;
  logic start_nxt;
  logic [9:0] track_cyc;
  logic busy_nxt;

  // The field is read live, so a rewrite during tracking shortens or stretches it
  assign track_cyc = 10'((adcawd_pkg::TRACK_STEPS - int'(tk_r)) * adcawd_pkg::TRACK_UNIT_CYC);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    ext_nxt = ext_r;
    left_nxt = left_r;
    start_nxt = 1'b0;
    case (state_r)
      adcawd_pkg::S_IDLE: begin
        if (conv_req) begin
          left_nxt = (burst_en && burst_len != 7'h00) ? burst_len : 7'h01;
          ext_nxt = 2'h0;
          // First conversion skips the burst track delay
          if (track_ext_en) begin
            state_nxt = adcawd_pkg::S_EXT;
          end else begin
            state_nxt = adcawd_pkg::S_CONV;
            start_nxt = 1'b1;
          end
        end
      end
      adcawd_pkg::S_TRACK: begin
        cnt_nxt = cnt_r + 10'h001;
        if (cnt_r + 10'h001 >= track_cyc) begin
          cnt_nxt = 10'h000;
          ext_nxt = 2'h0;
          if (track_ext_en) begin
            state_nxt = adcawd_pkg::S_EXT;
          end else begin
            state_nxt = adcawd_pkg::S_CONV;
            start_nxt = 1'b1;
          end
        end
      end
      adcawd_pkg::S_EXT: begin
        if (sar_tick) begin
          ext_nxt = ext_r + 2'h1;
          if (ext_r + 2'h1 == adcawd_pkg::EXT_SAR_CYC) begin
            state_nxt = adcawd_pkg::S_CONV;
            start_nxt = 1'b1;
          end
        end
      end
      adcawd_pkg::S_CONV: begin
        if (conv_done && !conv_start_r) begin
          left_nxt = left_r - 7'h01;
          if (left_r > 7'h01 && burst_en) begin
            state_nxt = adcawd_pkg::S_TRACK;
            cnt_nxt = 10'h000;
          end else begin
            state_nxt = adcawd_pkg::S_IDLE;
          end
        end
      end
      default: begin
        state_nxt = adcawd_pkg::S_IDLE;
      end
    endcase
    busy_nxt = (state_nxt != adcawd_pkg::S_IDLE);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= adcawd_pkg::S_IDLE;
      cnt_r <= 10'h000;
      ext_r <= 2'h0;
      left_r <= 7'h00;
      conv_start_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      ext_r <= ext_nxt;
      left_r <= left_nxt;
      conv_start_r <= start_nxt;
      busy_r <= busy_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [9:0] trk_seen_r;
  logic [3:0] ext_seen_r;
  // A rewrite of the track field while tracking legally bends the interval, so length is only checked without one
  logic tk_held_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trk_seen_r <= 10'h000;
      ext_seen_r <= 4'h0;
      tk_held_r <= 1'b1;
    end else begin
      trk_seen_r <= (state_r == adcawd_pkg::S_TRACK) ? trk_seen_r + 10'h001 : 10'h000;
      ext_seen_r <= (state_r != adcawd_pkg::S_EXT) ? 4'h0 : ext_seen_r + {3'h0, sar_tick};
      tk_held_r <= (state_r != adcawd_pkg::S_TRACK) || (tk_held_r && tk_nxt == tk_r);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence leave_track;
    state_r == adcawd_pkg::S_TRACK ##1 state_r == adcawd_pkg::S_EXT || state_r == adcawd_pkg::S_CONV;
  endsequence

  a_track_len: assert property (
    (state_r == adcawd_pkg::S_TRACK && state_nxt != adcawd_pkg::S_TRACK && tk_held_r)
      |-> trk_seen_r + 10'h001 == track_cyc)
    else $error("burst track interval has the wrong length");

  a_track_exit: assert property (
    leave_track |-> $past(trk_seen_r) + 10'h001 >= $past(track_cyc))
    else $error("track state left before its interval");

  a_first_notrack: assert property (
    state_r == adcawd_pkg::S_IDLE && conv_req |=> state_r != adcawd_pkg::S_TRACK)
    else $error("first conversion of a burst was delayed by track time");

  a_first_start: assert property (
    state_r == adcawd_pkg::S_IDLE && conv_req && !track_ext_en |=> conv_start_r)
    else $error("first conversion of a burst did not start at once");

  a_ext_three: assert property (
    state_r == adcawd_pkg::S_EXT ##1 state_r == adcawd_pkg::S_CONV |-> $past(ext_seen_r) == 4'h2 && $past(sar_tick))
    else $error("extension did not last three converter clocks");

  a_track_rsvd: assert property (
    sel_cfg && sfr_addr == adcawd_pkg::ADDR_TRACK |=> sfr_rdata_r[7:6] == 2'b00)
    else $error("reserved track bits read nonzero");

  a_res_read: assert property (
    sel_main && sfr_addr == adcawd_pkg::ADDR_RES_HI |=> sfr_rdata_r == $past(fmt[15:8]))
    else $error("high result byte read is not the formatted accumulator");

  a_res_write: assert property (
    sfr_wr && sel_main && sfr_addr == adcawd_pkg::ADDR_RES_LO |=> acc_r[7:0] == $past(sfr_wdata))
    else $error("low result byte write did not load the accumulator");

  a_shift_zero: assert property (
    shift_justify_field == 3'h3 |-> fmt[15:13] == 3'b000 && fmt[12:0] == acc_r[15:3])
    else $error("shifted high byte does not zero fill");

  a_shift_low: assert property (
    shift_justify_field == 3'h2 |-> fmt[7:6] == acc_r[9:8])
    else $error("low byte does not carry bits shifted out of the high byte");

  a_win_inside: assert property (
    gt_word < less_than_limit && fmt > gt_word && fmt < less_than_limit |=> window_match_r)
    else $error("window miss for data inside the limits");

  a_win_outside: assert property (
    gt_word >= less_than_limit && fmt >= less_than_limit && fmt <= gt_word |=> !window_match_r)
    else $error("window hit for data between the outside limits");

endmodule
`default_nettype wire
